/* File: src/phy_status_pkg.sv */
// Constants and types for the PHY management status and identifier registers.
// Assumes a 5-bit management register address and 16-bit register data.
package phy_status_pkg;

   // Management register addresses
   localparam logic [4:0] ADDR_BASIC_STATUS = 5'h01;
   localparam logic [4:0] ADDR_IDENT_HIGH = 5'h02;
   localparam logic [4:0] ADDR_IDENT_LOW = 5'h03;

   // Basic status field positions
   localparam int BIT_CAP_FAST_FULL = 14;
   localparam int BIT_CAP_FAST_HALF = 13;
   localparam int BIT_CAP_SLOW_FULL = 12;
   localparam int BIT_CAP_SLOW_HALF = 11;
   localparam int BIT_PREAMBLE_SUPPRESS = 6;
   localparam int BIT_NEG_COMPLETE = 5;
   localparam int BIT_FAR_END_FAULT = 4;
   localparam int BIT_NEG_ABLE = 3;
   localparam int BIT_LINK = 2;
   localparam int BIT_JABBER = 1;
   localparam int BIT_EXTENDED = 0;

   // Reset value of the basic status register
   localparam logic [15:0] BASIC_STATUS_RESET = 16'h7849;

   // Identifier values; arbitrary neutral values, not any real maker's code
   localparam logic [15:0] IDENT_HIGH_VALUE = 16'h0a5c;
   localparam logic [15:0] IDENT_LOW_VALUE = 16'h5c31;

   // Read request carried from the management access logic
   typedef struct packed {
      logic valid;
      logic [4:0] addr;
   } mgmt_read_req_t;

   // Read answer
   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } mgmt_read_rsp_t;

   // Live PHY conditions
   typedef struct packed {
      logic link_up;
      logic jabber_seen;
      logic far_fault_seen;
      logic neg_complete;
   } phy_cond_t;

endpackage

/* File: src/sync_two_ff.sv */
// Two flip-flop synchroniser for a group of level inputs.
// Assumes inputs are asynchronous levels; output is usable on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
   parameter int WIDTH = 4
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] hold_ff;
   logic [WIDTH-1:0] nxt_meta;
   logic [WIDTH-1:0] nxt_hold;

   // Next values of the two stages
   always_comb begin
      nxt_meta = async_in;
      nxt_hold = meta_ff;
      if (srst) begin
         nxt_meta = '0;
         nxt_hold = '0;
      end
   end

   // Stage registers; only the second stage reads the first
   always_ff @(posedge clk_sys) begin
      meta_ff <= nxt_meta;
      hold_ff <= nxt_hold;
   end

   assign sync_out = hold_ff;
endmodule
`default_nettype wire

/* File: src/phy_mgmt_status_ident_regs.sv */
// Read side of the PHY basic status and identifier registers.
// Assumes the management access logic on clk_sys presents one-cycle read
// requests; PHY condition inputs come from other domains and are synchronised.
`timescale 1ns/1ps
`default_nettype none

// Register map served by this block (5-bit management address):
//    0x01  basic status, read only, sticky bits clear on read
//    0x02  identifier high half, read only, constant
//    0x03  identifier low half, read only, constant
//    other addresses answer with data 0
//
// Basic status layout:
//    15     reserved, reads 0
//    14:11  speed and duplex capabilities, read 1
//    10:7   reserved, read 0
//    6      preamble suppression capable, reads 1
//    5      negotiation complete, live
//    4      far-end fault, sticky, cleared by a status read
//    3      negotiation able, reads 1
//    2      link state, live
//    1      jabber, sticky, cleared by a status read
//    0      extended registers present, reads 1
//
// Timing: a request is taken at the rising edge where it stands and the
// answer stands for exactly one cycle after that edge. Condition inputs
// reach the status word two edges after they change, through the
// synchroniser, and one more edge for the registered flags.

// Function
// - Status bits 14 and 13 read fixed 1: 100 Mb/s full and half duplex.
// - Status bits 12 and 11 read fixed 1: 10 Mb/s full and half duplex.
// - Status bit 2 shows current link state; reset value 0.
// - Status bit 1 latches jabber until the status register is read.
// - Status bit 0 always reads 1: extended registers present.
// - Address 0x02 returns upper half of 32-bit identifier, read only.
// - Maker code spans identifier high and top six bits of identifier low.
// - Basic status at address 0x01, read only, reset value 0x7849.
module phy_mgmt_status_ident_regs
   import phy_status_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   input wire mgmt_read_req_t rd_req,
   input wire phy_cond_t phy_cond,
   output mgmt_read_rsp_t rd_rsp,
   output logic link_up,
   output logic jabber_flag,
   output logic far_end_fault_flag
);
   // Synchronised PHY conditions
   phy_cond_t cond_sync;

   // Link state group
   logic link_ff;
   logic nxt_link;

   // Sticky event group
   logic jabber_ff;
   logic nxt_jabber;
   logic fault_ff;
   logic nxt_fault;

   // Read answer group
   mgmt_read_rsp_t rsp_ff;
   mgmt_read_rsp_t nxt_rsp;

   // Decoded read strobes, valid only in the request cycle
   logic status_read;
   logic ident_high_read;
   logic ident_low_read;

   // Status word as a read in this cycle would return it
   logic [15:0] status_word;

   // Condition inputs arrive from PHY analog and line domains
   sync_two_ff #(.WIDTH($bits(phy_cond_t))) u_cond_sync (
      .clk_sys(clk_sys),
      .srst(srst),
      .async_in(phy_cond),
      .sync_out(cond_sync)
   );

   // Assemble the live status word
   function automatic logic [15:0] build_status(input logic link_v, input logic jab_v,
                                                input logic flt_v, input logic neg_v);
      logic [15:0] w;
      w = 16'h0000; // Reserved bits read 0
      w[BIT_CAP_FAST_FULL] = 1'b1;
      w[BIT_CAP_FAST_HALF] = 1'b1;
      w[BIT_CAP_SLOW_FULL] = 1'b1;
      w[BIT_CAP_SLOW_HALF] = 1'b1;
      w[BIT_PREAMBLE_SUPPRESS] = BASIC_STATUS_RESET[BIT_PREAMBLE_SUPPRESS];
      w[BIT_NEG_COMPLETE] = neg_v;
      w[BIT_FAR_END_FAULT] = flt_v;
      w[BIT_NEG_ABLE] = BASIC_STATUS_RESET[BIT_NEG_ABLE];
      w[BIT_LINK] = link_v;
      w[BIT_JABBER] = jab_v;
      w[BIT_EXTENDED] = 1'b1;
      return w;
   endfunction

   // True when a valid request names the given register
   function automatic logic addr_hit(input mgmt_read_req_t req, input logic [4:0] reg_addr);
      return req.valid && (req.addr == reg_addr);
   endfunction

   // Sticky update: an event in the read cycle beats the read clear,
   // so a condition seen while software reads is never lost
   function automatic logic sticky_next(input logic event_v, input logic held_v,
                                        input logic clear_v);
      return event_v | (held_v & ~clear_v);
   endfunction

   // Register decode
   assign status_read = addr_hit(rd_req, ADDR_BASIC_STATUS);
   assign ident_high_read = addr_hit(rd_req, ADDR_IDENT_HIGH);
   assign ident_low_read = addr_hit(rd_req, ADDR_IDENT_LOW);

   // Status word from the registered flags; bit 5 follows its input live
   assign status_word = build_status(link_ff, jabber_ff, fault_ff, cond_sync.neg_complete);

   // Link state: follows the synchronised level, no latching
   always_comb begin
      nxt_link = cond_sync.link_up;
      if (srst) begin
         nxt_link = BASIC_STATUS_RESET[BIT_LINK];
      end
   end

   // Link state register
   always_ff @(posedge clk_sys) begin
      link_ff <= nxt_link;
   end

   // Sticky flags: set by the event, cleared by a status read
   always_comb begin
      nxt_jabber = sticky_next(cond_sync.jabber_seen, jabber_ff, status_read);
      nxt_fault = sticky_next(cond_sync.far_fault_seen, fault_ff, status_read);
      if (srst) begin
         nxt_jabber = BASIC_STATUS_RESET[BIT_JABBER];
         nxt_fault = BASIC_STATUS_RESET[BIT_FAR_END_FAULT];
      end
   end

   // Sticky flag registers
   always_ff @(posedge clk_sys) begin
      jabber_ff <= nxt_jabber;
      fault_ff <= nxt_fault;
   end

   // Read answer one cycle after the request; data is 0 while not valid
   // so a host that ignores the valid bit never sees stale values
   always_comb begin
      nxt_rsp.valid = rd_req.valid;
      nxt_rsp.data = 16'h0000; // Unlisted addresses read 0
      if (status_read) begin
         nxt_rsp.data = status_word;
      end else if (ident_high_read) begin
         nxt_rsp.data = IDENT_HIGH_VALUE;
      end else if (ident_low_read) begin
         nxt_rsp.data = IDENT_LOW_VALUE;
      end else begin
         nxt_rsp.data = 16'h0000;
      end
      if (srst) begin
         nxt_rsp = '0;
      end
   end

   // Read answer register
   always_ff @(posedge clk_sys) begin
      rsp_ff <= nxt_rsp;
   end

   // Outputs come straight from the registers
   assign rd_rsp = rsp_ff;
   assign link_up = link_ff;
   assign jabber_flag = jabber_ff;
   assign far_end_fault_flag = fault_ff;
endmodule
`default_nettype wire

/* File: tb/stat_sva.sv */
// Checks on the status read port.
// Assumes one clock, answer on the next edge.
`timescale 1ns/1ps
`default_nettype none
module stat_sva import phy_status_pkg::*; (
   input wire logic clk_sys,
   input wire logic srst,
   input wire mgmt_read_req_t rd_req,
   input wire mgmt_read_rsp_t rd_rsp,
   input wire logic link_up,
   input wire logic jabber_flag,
   input wire logic far_end_fault_flag
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   // Status read taken at this edge
   wire logic st = rd_req == {1'b1, ADDR_BASIC_STATUS};
   chk_answer_next: assert property (rd_req.valid |=> rd_rsp.valid)
      else $error("no answer");
   chk_cap_bits: assert property (st |=> rd_rsp.data[14:11] == 4'hf)
      else $error("caps");
   chk_fixed_bits: assert property (st |=> (rd_rsp.data & 16'h87c9) == 16'h0049)
      else $error("fixed");
   chk_ident_high: assert property (rd_req == {1'b1, ADDR_IDENT_HIGH}
      |=> rd_rsp.data == IDENT_HIGH_VALUE) else $error("ident");
   chk_link_bit: assert property (st |=> rd_rsp.data[2] == $past(link_up))
      else $error("link");
   chk_jab_bit: assert property (st |=> rd_rsp.data[1] == $past(jabber_flag))
      else $error("jabber");
   chk_jab_hold: assert property (jabber_flag && !st |=> jabber_flag)
      else $error("jabber lost");
   chk_fault_hold: assert property (far_end_fault_flag && !st |=> far_end_fault_flag)
      else $error("fault lost");
   chk_idle_zero: assert property (!rd_req.valid |=> rd_rsp == '0)
      else $error("idle answer not zero");
endmodule
`default_nettype wire

/* File: tb/mgmt_host.sv */
// Management host: issues one-cycle reads.
// Assumes the answer comes one edge after.
`timescale 1ns/1ps
`default_nettype none
module mgmt_host import phy_status_pkg::*; (
   input wire logic clk_sys,
   output mgmt_read_req_t rd_req = '0,
   input wire mgmt_read_rsp_t rd_rsp
);
   // Raise after an edge, drop after the taking edge, then read
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk_sys) rd_req <= {1'b1, a};
      @(posedge clk_sys) rd_req <= '0;
      #1 d = rd_rsp.valid ? rd_rsp.data : 16'hdead;
   endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Bench: status and identifier reads.
// Assumes host and checker built first.
`timescale 1ns/1ps
`default_nettype none
module testbench import phy_status_pkg::*;;
   logic clk_sys = 0, srst = 1, link_up, jabber_flag, far_end_fault_flag;
   phy_cond_t phy_cond = '0;
   mgmt_read_req_t rd_req;
   mgmt_read_rsp_t rd_rsp;
   int n_mismatch = 0, checks = 0;
   initial forever #5 clk_sys = ~clk_sys;
   mgmt_host u_mgmt_host (.clk_sys, .rd_req, .rd_rsp);
   phy_mgmt_status_ident_regs u_phy_mgmt_status_ident_regs (.clk_sys, .srst, .rd_req,
      .phy_cond, .rd_rsp, .link_up, .jabber_flag, .far_end_fault_flag);
   // Compare one value with its expectation
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s exp %h got %h", what, exp, seen);
      end
   endtask
   // Read and compare
   task rdc(input logic [4:0] a, input logic [15:0] e);
      logic [15:0] g;
      u_mgmt_host.rd(a, g);
      check($sformatf("reg %h", a), g, e);
   endtask
   // Compare the three flag outputs
   task flags(input logic [2:0] e);
      check("flags", {13'h0000, link_up, jabber_flag, far_end_fault_flag}, {13'h0000, e});
   endtask
   // Held jabber survives reads, then clears once gone
   task t_hold;
      @(posedge clk_sys) phy_cond <= 4'h4;
      repeat (4) @(posedge clk_sys);
      rdc(ADDR_BASIC_STATUS, 16'h784b);
      rdc(ADDR_BASIC_STATUS, 16'h784b);
      flags(3'b010);
      @(posedge clk_sys) phy_cond <= '0;
      repeat (4) @(posedge clk_sys);
      rdc(ADDR_BASIC_STATUS, 16'h784b);
      rdc(ADDR_BASIC_STATUS, 16'h7849);
      flags(3'b000);
   endtask
   // Mid-run reset drops latched flags
   task t_reset;
      @(posedge clk_sys) phy_cond <= 4'h6;
      repeat (4) @(posedge clk_sys);
      #1 flags(3'b011);
      @(posedge clk_sys) srst <= 1;
      phy_cond <= '0;
      repeat (3) @(posedge clk_sys);
      srst <= 0;
      #1 flags(3'b000);
      rdc(ADDR_BASIC_STATUS, 16'h7849);
   endtask
   // Identifier and unmapped
   task t_ident;
      rdc(ADDR_IDENT_HIGH, IDENT_HIGH_VALUE);
      rdc(ADDR_IDENT_LOW, IDENT_LOW_VALUE);
      rdc(5'h1f, 16'h0000);
   endtask
   // Live and sticky bits
   task t_cond;
      @(posedge clk_sys) phy_cond <= '1;
      repeat (4) @(posedge clk_sys);
      phy_cond <= 4'h9;
      repeat (4) @(posedge clk_sys);
      #1 flags(3'b111);
      rdc(ADDR_BASIC_STATUS, 16'h787f);
      flags(3'b100);
      rdc(ADDR_BASIC_STATUS, 16'h786d);
      @(posedge clk_sys) phy_cond <= '0;
      repeat (4) @(posedge clk_sys);
      rdc(ADDR_BASIC_STATUS, 16'h7849);
   endtask
   // Verdict
   task conclude;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge clk_sys);
      srst <= 0;
      rdc(ADDR_BASIC_STATUS, 16'h7849);
      t_ident;
      t_cond;
      t_hold;
      t_reset;
      conclude;
   end
endmodule
bind phy_mgmt_status_ident_regs stat_sva u_stat_sva (.clk_sys, .srst, .rd_req, .rd_rsp,
   .link_up, .jabber_flag, .far_end_fault_flag);
`default_nettype wire
